// ==== bench/acsc_checker.sv ====
`timescale 1ns/1ps
module acsc_checker (
  input logic                       CLK,
  input logic                       RESET_N,
  input acsc_pkg::acsc_apb_req_t    APB_REQ,
  input logic                       PREADY,
  input logic                       PSLVERR,
  input acsc_pkg::acsc_pin_drv_t    MULTIPIN_DRV,
  input logic                       PULSE_OUT,
  input logic                       INT_N,
  input acsc_pkg::acsc_cmp_share_t  CMP_SHARE
);
  import acsc_pkg::*;
  // ----
  // shadow of the written configuration
  // ----
  logic       msk_reg, tmr_reg;
  logic [3:0] pm_reg;
  logic [1:0] en_reg;
  wire wr_ok = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & PREADY & !PSLVERR;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      msk_reg <= 1'b0;
      tmr_reg <= 1'b0;
      pm_reg  <= 4'h0;
      en_reg  <= 2'h0;
    end else if (wr_ok) begin
      case (APB_REQ.paddr)
        OFS_PULSE_ENV:  msk_reg <= APB_REQ.pwdata[PULSE_MASK_BIT];
        OFS_OP_MODE:    tmr_reg <= APB_REQ.pwdata[TIMER_MODE_BIT];
        OFS_PIN_ENV:    pm_reg  <= APB_REQ.pwdata[PIN_MODE_LSB+:4];
        OFS_EVT_ENABLE: en_reg  <= APB_REQ.pwdata[EVT_LSB+:2];
        default: ;
      endcase
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_answer: assert property (APB_REQ.psel && !APB_REQ.penable |=> PREADY)
    else $error("no ready after setup");
  a_pulse_hidden: assert property (msk_reg && $past(msk_reg) |-> !PULSE_OUT)
    else $error("pulse while masked");
  a_timer_quiet: assert property (tmr_reg && $past(tmr_reg) |-> !PULSE_OUT)
    else $error("pulse in timer mode");
  a_pin_one_input: assert property (pm_reg[1:0] == 2'h0 && $past(pm_reg[1:0]) == 2'h0
    && $past(pm_reg[1:0], 2) == 2'h0 |-> !MULTIPIN_DRV.oe[0]) else $error("pin one driven");
  a_pin_two_drives: assert property (pm_reg[3:2] != 2'h0 && $past(pm_reg[3:2]) != 2'h0
    && $past(pm_reg[3:2], 2) != 2'h0 |-> MULTIPIN_DRV.oe[1]) else $error("pin two idle");
  a_pin_one_pos: assert property (pm_reg[1:0] == 2'h3 && $past(pm_reg[1:0]) == 2'h3
    && CMP_SHARE.match_event[0] |=> MULTIPIN_DRV.o[0]) else $error("pin one not high");
  a_pin_two_neg: assert property (pm_reg[3:2] == 2'h2 && $past(pm_reg[3:2]) == 2'h2
    && CMP_SHARE.match_event[1] |=> !MULTIPIN_DRV.o[1]) else $error("pin two not low");
  a_int_cause: assert property (!INT_N |-> en_reg != 2'h0)
    else $error("interrupt without enable");
  a_int_raise: assert property ((CMP_SHARE.match_event & en_reg & $past(en_reg)) != 2'h0
    |-> !INT_N) else $error("interrupt not raised");
  a_int_hold: assert property (!INT_N && !wr_ok && !$past(wr_ok) |=> !INT_N)
    else $error("interrupt dropped");
  a_match_pulse: assert property (CMP_SHARE.match_event[0] |=> !CMP_SHARE.match_event[0])
    else $error("match pulse too long");
endmodule : acsc_checker

// ==== bench/acsc_pin_partner.sv ====
`timescale 1ns/1ps
module acsc_pin_partner (
  input logic                     CLK,
  input acsc_pkg::acsc_pin_drv_t  drv,
  input logic [1:0]               ext_in,
  output logic [1:0]              pin_i
);
  import acsc_pkg::*;
  // equipment only drives a pin that the device has let go of
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_i[i] = drv.oe[i] ? drv.o[i] : ext_in[i];
    end
  end
endmodule : acsc_pin_partner

// ==== bench/acsc_top_test.sv ====
`timescale 1ns/1ps
module acsc_top_test;
  import acsc_pkg::*;
  localparam logic [7:0]  RO[7] = '{OFS_PULSE_ENV, OFS_PIN_ENV, OFS_COUNTER_ENV, OFS_OP_MODE,
                                   OFS_EVT_ENABLE, OFS_EVT_CAUSE, OFS_MAIN_STATUS};
  localparam logic [31:0] SRC[5] = '{0, 0, 0, 'h10, 0};
  localparam logic [31:0] HLT[5] = '{0, 4, 8, 0, 0};
  localparam logic [31:0] E1[5]  = '{'h103, 'h100, 'h103, 'h100, 'hfd};
  localparam logic [31:0] E2[5]  = '{'h103, 'h103, 'h100, 'h103, 'hfd};
  localparam logic [31:0] OPM[5] = '{2, 'h802, 3, 2, 2};
  localparam logic [31:0] PE[5]  = '{0, 0, 0, 'h2000, 0};
  localparam logic [31:0] HL2[5] = '{0, 0, 0, 0, 'hc};
  localparam int          KC[5]  = '{1, 0, 0, 2, 0};
  localparam logic [31:0] PK[5]  = '{1, 1, 0, 0, 1};
  logic            CLK = 1'b0;
  logic            RESET_N = 1'b0;
  acsc_apb_req_t   APB_REQ = '0;
  logic            PREADY, PSLVERR, PULSE_OUT, INT_N;
  logic [31:0]     PRDATA, rd, c1, c2;
  logic            COUNT_PULSE = 1'b0;
  logic            COUNT_DOWN = 1'b0;
  logic [1:0]      ext_in = 2'b10;
  wire logic [1:0] MULTIPIN_I;
  acsc_pin_drv_t   MULTIPIN_DRV;
  acsc_cmp_share_t CMP_SHARE;
  int              n_mismatch = 0, samples_checked = 0, cyc = 0, npulse = 0;

  acsc_top uut (.CLK(CLK), .RESET_N(RESET_N), .APB_REQ(APB_REQ), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .COUNT_PULSE(COUNT_PULSE), .COUNT_DOWN(COUNT_DOWN),
    .MULTIPIN_I(MULTIPIN_I), .MULTIPIN_DRV(MULTIPIN_DRV), .PULSE_OUT(PULSE_OUT),
    .INT_N(INT_N), .CMP_SHARE(CMP_SHARE));
  acsc_pin_partner far (.CLK(CLK), .drv(MULTIPIN_DRV), .ext_in(ext_in), .pin_i(MULTIPIN_I));

  always #2.5 CLK = ~CLK;
  // ----
  // bus and compare tasks
  // ----
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // the run needs under 1000 cycles, so this only trips on a hang
  always @(posedge CLK) begin
    cyc++;
    if (PULSE_OUT === 1'b1) npulse++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    APB_REQ <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge CLK);
    APB_REQ.penable <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    APB_REQ <= '0;
    @(posedge CLK);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task snap;
    apb(1'b0, OFS_CNT_ONE, 32'h0);
    c1 = rd;
    apb(1'b0, OFS_CNT_TWO, 32'h0);
    c2 = rd;
  endtask : snap
  // ----
  // scenarios
  // ----
  task t_reset;
    for (int i = 0; i < 7; i++) rdchk(RO[i], RST_WORD);
    rdchk(OFS_PULSE_PER, {16'h0, RST_PER});
    chk({31'h0, INT_N}, 32'h1);
    wr(OFS_MAIN_STATUS, 32'hffff_ffff);
    rdchk(OFS_MAIN_STATUS, 32'h0);
    APB_REQ <= '{psel: 1'b1, penable: 1'b0, pwrite: 1'b0, paddr: 8'h3c, pwdata: 32'h0};
    @(posedge CLK);
    APB_REQ.penable <= 1'b1;
    @(posedge CLK);
    chk({PREADY, PSLVERR, PRDATA[29:0]}, 32'hc000_0000);
    APB_REQ <= '0;
    @(posedge CLK);
    $display("t_reset done");
  endtask : t_reset
  task t_compare;
    logic [27:0] v;
    logic        m;
    wr(OFS_CNT_ONE, 32'h0800_0000);
    wr(OFS_CNT_TWO, 32'h10);
    for (int c = 0; c < 4; c++) begin
      for (int k = -1; k < 2; k++) begin
        v = 28'(32'h0800_0000 + k);
        m = (c == 1 && k == 0) || (c == 2 && k > 0) || (c == 3 && k < 0);
        wr(OFS_CMP_ONE, {4'h0, v});
        wr(OFS_CMP_TWO, 32'(32'h10 + k));
        wr(OFS_COUNTER_ENV, 32'(c * 32'h5000));
        rdchk(OFS_MAIN_STATUS, {22'h0, m, m, 8'h0});
        chk({4'h0, CMP_SHARE.cmp_value[0]}, {4'h0, v});
        chk({4'h0, CMP_SHARE.cmp_value[1]}, 32'(32'h10 + k));
      end
    end
    $display("t_compare done");
  endtask : t_compare
  task t_event;
    logic [31:0] b;
    for (int i = 0; i < 2; i++) begin
      b = 32'h40 << i;
      wr(OFS_COUNTER_ENV, 32'h1000 << (2 * i));
      wr(i ? OFS_CMP_TWO : OFS_CMP_ONE, 32'h30);
      wr(i ? OFS_CNT_TWO : OFS_CNT_ONE, 32'h2f);
      wr(OFS_EVT_CAUSE, 32'hc0);
      wr(OFS_EVT_ENABLE, b);
      chk({31'h0, INT_N}, 32'h1);
      wr(i ? OFS_CNT_TWO : OFS_CNT_ONE, 32'h30);
      // cause and interrupt register one edge after the counter lands
      tick(1);
      chk({31'h0, INT_N}, 32'h0);
      rdchk(OFS_EVT_CAUSE, b);
      wr(OFS_EVT_ENABLE, 32'h0);
      chk({31'h0, INT_N}, 32'h1);
      wr(OFS_EVT_ENABLE, b);
      chk({31'h0, INT_N}, 32'h0);
      wr(OFS_EVT_CAUSE, b);
      chk({31'h0, INT_N}, 32'h1);
      rdchk(OFS_EVT_CAUSE, 32'h0);
    end
    wr(OFS_EVT_ENABLE, 32'h0);
    $display("t_event done");
  endtask : t_event
  task t_pins;
    wr(OFS_CMP_ONE, 32'h55);
    wr(OFS_CNT_ONE, 32'h55);
    wr(OFS_CMP_TWO, 32'h55);
    wr(OFS_CNT_TWO, 32'h55);
    wr(OFS_PIN_DATA, 32'h1);
    for (int ms = 0; ms < 2; ms++) begin
      wr(OFS_COUNTER_ENV, ms ? 32'h5000 : 32'h0);
      for (int md = 0; md < 4; md++) begin
        wr(OFS_PIN_ENV, 32'(md * 32'h140));
        // drive settles one edge later, the read-back input two more
        tick(2);
        chk(32'(MULTIPIN_DRV.oe), md ? 32'h3 : 32'h0);
        if (md == 0) rdchk(OFS_PIN_DATA, 32'h21);
        else chk(32'(MULTIPIN_DRV.o), md == 1 ? 32'h1 : ((md == 3) == ms) ? 32'h3 : 32'h0);
      end
    end
    wr(OFS_COUNTER_ENV, 32'h0);
    wr(OFS_PIN_ENV, 32'h2c0);
    wr(OFS_COUNTER_ENV, 32'h5000);
    tick(2);
    chk(32'(MULTIPIN_DRV.o), 32'h1);
    wr(OFS_COUNTER_ENV, 32'h0);
    $display("t_pins done");
  endtask : t_pins
  task t_count;
    int p;
    for (int s = 0; s < 5; s++) begin
      wr(OFS_CNT_SOURCE, SRC[s]);
      wr(OFS_COUNTER_ENV, HLT[s]);
      wr(OFS_CNT_ONE, 32'h100);
      wr(OFS_CNT_TWO, 32'h100);
      COUNT_DOWN <= (s == 4);
      repeat (3) begin
        COUNT_PULSE <= 1'b1;
        tick(3);
        COUNT_PULSE <= 1'b0;
        tick(3);
      end
      tick(4);
      snap();
      chk(c1, E1[s]);
      chk(c2, E2[s]);
    end
    wr(OFS_CNT_SOURCE, 32'h3);
    for (int s = 0; s < 5; s++) begin
      wr(OFS_PULSE_ENV, PE[s]);
      wr(OFS_COUNTER_ENV, HL2[s]);
      wr(OFS_CNT_ONE, 32'h0);
      wr(OFS_CNT_TWO, 32'h0);
      p = npulse;
      wr(OFS_OP_MODE, OPM[s]);
      tick(30);
      wr(OFS_OP_MODE, 32'h0);
      tick(4);
      p = npulse - p;
      snap();
      chk(32'(p != 0), PK[s]);
      chk(KC[s] == 2 ? 32'(c1 != 0) : c1, KC[s] == 1 ? p : 32'(KC[s] == 2));
      chk(KC[s] == 2 ? 32'(c2 != 0) : c2, KC[s] == 1 ? p : 32'(KC[s] == 2));
    end
    $display("t_count done");
  endtask : t_count

  initial begin
    tick(20);
    RESET_N <= 1'b1;
    tick(1);
    t_reset();
    t_compare();
    t_event();
    t_pins();
    t_count();
    close_out();
  end
endmodule : acsc_top_test

bind acsc_top acsc_checker chk_i (.CLK(CLK), .RESET_N(RESET_N), .APB_REQ(APB_REQ),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MULTIPIN_DRV(MULTIPIN_DRV), .PULSE_OUT(PULSE_OUT),
  .INT_N(INT_N), .CMP_SHARE(CMP_SHARE));

// ==== core/acsc_pkg.sv ====
// Function
// - halt bits two and three stop counters
// - halting ignores the selected count source
// - masked count input freezes its counter
// - timer mode blocks output pulse counting
// - operating mode bit eleven masks pulse counting
// - pulse mask suppresses pins, counting continues
// - two 28-bit comparators per axis
// - each comparator pairs register with counter
// - comparator one condition in bits 13:12
// - comparator two condition in bits 15:14
// - enabled comparator match raises event interrupt
// - event cause bits six and seven
// - status word bits eight and nine
// - first multipurpose pin mode bits 7:6
// - second multipurpose pin mode bits 9:8
// - compare values and matches feed other functions
package acsc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CNT_W   = 28;
  localparam int NCNT    = 2;
  localparam int PER_W   = 16;
  localparam int ADDR_W  = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PULSE_ENV   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_ENV     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_ENV = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OP_MODE     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_CAUSE   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MAIN_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMP_ONE     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CMP_TWO     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT_ONE     = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CNT_TWO     = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA    = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CNT_SOURCE  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_PULSE_PER   = 8'h34;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PULSE_MASK_BIT  = 13;  // pulse_env_config
  localparam int TIMER_MODE_BIT  = 0;   // operating_mode
  localparam int PULSE_RUN_BIT   = 1;
  localparam int PULSE_DOWN_BIT  = 2;
  localparam int PCNT_MASK_BIT   = 11;
  localparam int HALT_LSB        = 2;   // counter_env_config, one bit per counter
  localparam int COND_LSB        = 12;  // two bits per comparator
  localparam int PIN_MODE_LSB    = 6;   // pin_env_config, two bits per pin
  localparam int EVT_LSB         = 6;   // event enable and cause
  localparam int STAT_LSB        = 8;   // main status word
  localparam int PIN_IN_LSB      = 4;   // pin_data: inputs above outputs
  localparam int SRC_MASK_LSB    = 4;   // cnt_source: external mask bits
  localparam int MAIN_STATUS_W   = 16;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACSC_COND_OFF  = 2'h0,
    ACSC_COND_EQ   = 2'h1,
    ACSC_COND_GT   = 2'h2,
    ACSC_COND_LT   = 2'h3
  } acsc_cond_t;

  typedef enum logic [1:0] {
    ACSC_PIN_IN    = 2'h0,
    ACSC_PIN_OUT   = 2'h1,
    ACSC_PIN_CMP_N = 2'h2,
    ACSC_PIN_CMP_P = 2'h3
  } acsc_pin_t;

  localparam logic [31:0]      RST_WORD  = 32'h0000_0000;
  localparam logic [PER_W-1:0] RST_PER   = 16'h0001;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } acsc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } acsc_apb_rsp_t;

  typedef struct packed {
    logic [NCNT-1:0] o;
    logic [NCNT-1:0] oe;
  } acsc_pin_drv_t;

  typedef struct packed {
    logic [NCNT-1:0][CNT_W-1:0] cmp_value;
    logic [NCNT-1:0]            match_event;
  } acsc_cmp_share_t;

endpackage : acsc_pkg

// ==== core/acsc_top.sv ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module acsc_top (
  input  wire logic                    CLK,
  input  wire logic                    RESET_N,
  input  wire acsc_pkg::acsc_apb_req_t APB_REQ,
  output logic                         PREADY,
  output logic [31:0]                  PRDATA,
  output logic                         PSLVERR,
  input  wire logic                    COUNT_PULSE,
  input  wire logic                    COUNT_DOWN,
  input  wire logic [1:0]              MULTIPIN_I,
  output acsc_pkg::acsc_pin_drv_t      MULTIPIN_DRV,
  output logic                         PULSE_OUT,
  output logic                         INT_N,
  output acsc_pkg::acsc_cmp_share_t    CMP_SHARE
);
  import acsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                pulse_env;
    logic [31:0]                pin_env;
    logic [31:0]                counter_env;
    logic [31:0]                op_mode;
    logic [NCNT-1:0]            evt_enable;
    logic [NCNT-1:0]            evt_cause;
    logic [NCNT-1:0][CNT_W-1:0] cmp;
    logic [NCNT-1:0][CNT_W-1:0] cnt;
    logic [NCNT-1:0]            gp_out;
    logic [NCNT-1:0]            src_pulse;
    logic [NCNT-1:0]            ext_mask;
    logic [PER_W-1:0]           pulse_per;
    logic [PER_W-1:0]           pulse_tmr;
    logic [NCNT-1:0]            match;
    logic [NCNT-1:0]            match_evt;
    logic [3:0]                 pin_s1;
    logic [3:0]                 pin_s2;
    logic                       cin_prev;
    logic                       pulse_out;
    logic                       int_n;
    acsc_pin_drv_t              pin_drv;
    acsc_apb_rsp_t              rsp;
  } acsc_state_t;

  acsc_state_t st_reg;
  acsc_state_t st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic cond_met(input logic [1:0] cond,
                                    input logic [CNT_W-1:0] cmpv,
                                    input logic [CNT_W-1:0] cntv);
    logic r;
    r = 1'b0;
    unique case (acsc_cond_t'(cond))
      ACSC_COND_OFF: r = 1'b0;
      ACSC_COND_EQ:  r = (cmpv == cntv);
      ACSC_COND_GT:  r = (cmpv > cntv);
      ACSC_COND_LT:  r = (cmpv < cntv);
    endcase
    return r;
  endfunction : cond_met

  function automatic logic [1:0] pin_drive(input logic [1:0] mode,
                                           input logic gp,
                                           input logic m);
    logic [1:0] r;  // {oe, o}
    r = 2'h0;
    unique case (acsc_pin_t'(mode))
      ACSC_PIN_IN:    r = 2'h0;
      ACSC_PIN_OUT:   r = {1'b1, gp};
      ACSC_PIN_CMP_N: r = {1'b1, ~m};
      ACSC_PIN_CMP_P: r = {1'b1, m};
    endcase
    return r;
  endfunction : pin_drive

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic                       wr_access;
  logic                       setup;
  logic                       mapped;
  logic [31:0]                rd_word;
  logic                       ext_edge;
  logic                       ext_down;
  logic                       pulse_tick;
  logic                       timer_mode;
  logic [NCNT-1:0]            step_en;
  logic [NCNT-1:0]            match_now;
  logic [1:0]                 drv;
  logic [MAIN_STATUS_W-1:0]   status_w;

  always_comb begin
    st_next    = st_reg;
    rd_word    = RST_WORD;
    mapped     = 1'b1;
    drv        = 2'h0;
    status_w   = '0;
    step_en    = '0;
    match_now  = '0;
    setup      = APB_REQ.psel & ~APB_REQ.penable;
    wr_access  = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & st_reg.rsp.pready;
    timer_mode = st_reg.op_mode[TIMER_MODE_BIT];

    // only the second synchroniser stage and its delayed copy feed logic
    st_next.pin_s1   = {MULTIPIN_I, COUNT_DOWN, COUNT_PULSE};
    st_next.pin_s2   = st_reg.pin_s1;
    st_next.cin_prev = st_reg.pin_s2[0];
    ext_edge         = st_reg.pin_s2[0] & ~st_reg.cin_prev;
    ext_down         = st_reg.pin_s2[1];

    // ----------------------------------------------------------------
    // output pulse generator
    // ----------------------------------------------------------------
    pulse_tick = 1'b0;
    if (st_reg.op_mode[PULSE_RUN_BIT]) begin
      if (st_reg.pulse_tmr >= st_reg.pulse_per) begin
        st_next.pulse_tmr = '0;
        pulse_tick        = 1'b1;
      end else begin
        st_next.pulse_tmr = st_reg.pulse_tmr + 1'b1;
      end
    end else begin
      st_next.pulse_tmr = '0;
    end
    // timer mode makes ticks but no pins toggle; the mask hides the pin only
    st_next.pulse_out = pulse_tick & ~timer_mode & ~st_reg.pulse_env[PULSE_MASK_BIT];

    // ----------------------------------------------------------------
    // counters and comparators
    // ----------------------------------------------------------------
    for (int i = 0; i < NCNT; i++) begin
      if (st_reg.src_pulse[i]) begin
        // pulse mask on the pin does not stop this count
        step_en[i] = pulse_tick & ~timer_mode
                   & ~st_reg.op_mode[PCNT_MASK_BIT];
      end else begin
        step_en[i] = ext_edge & ~st_reg.ext_mask[i];
      end
      // halt applies after source selection so every source obeys it
      step_en[i] = step_en[i] & ~st_reg.counter_env[HALT_LSB + i];
      if (step_en[i]) begin
        if (st_reg.src_pulse[i] ? st_reg.op_mode[PULSE_DOWN_BIT] : ext_down) begin
          st_next.cnt[i] = st_reg.cnt[i] - 1'b1;
        end else begin
          st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
        end
      end
      // registered compare keeps the 28-bit magnitude path off the bus path
      match_now[i] = cond_met(st_reg.counter_env[COND_LSB + 2*i +: 2],
                              st_reg.cmp[i], st_reg.cnt[i]);
      st_next.match[i]     = match_now[i];
      st_next.match_evt[i] = match_now[i] & ~st_reg.match[i];
      drv = pin_drive(st_reg.pin_env[PIN_MODE_LSB + 2*i +: 2],
                      st_reg.gp_out[i], st_reg.match[i]);
      st_next.pin_drv.oe[i] = drv[1];
      st_next.pin_drv.o[i]  = drv[0];
    end

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    status_w[STAT_LSB +: NCNT] = st_reg.match;
    unique case (APB_REQ.paddr)
      OFS_PULSE_ENV:   rd_word = st_reg.pulse_env;
      OFS_PIN_ENV:     rd_word = st_reg.pin_env;
      OFS_COUNTER_ENV: rd_word = st_reg.counter_env;
      OFS_OP_MODE:     rd_word = st_reg.op_mode;
      OFS_EVT_ENABLE:  rd_word[EVT_LSB +: NCNT] = st_reg.evt_enable;
      OFS_EVT_CAUSE:   rd_word[EVT_LSB +: NCNT] = st_reg.evt_cause;
      OFS_MAIN_STATUS: rd_word[MAIN_STATUS_W-1:0] = status_w;
      OFS_CMP_ONE:     rd_word[CNT_W-1:0] = st_reg.cmp[0];
      OFS_CMP_TWO:     rd_word[CNT_W-1:0] = st_reg.cmp[1];
      OFS_CNT_ONE:     rd_word[CNT_W-1:0] = st_reg.cnt[0];
      OFS_CNT_TWO:     rd_word[CNT_W-1:0] = st_reg.cnt[1];
      OFS_PIN_DATA: begin
        rd_word[NCNT-1:0]             = st_reg.gp_out;
        rd_word[PIN_IN_LSB +: NCNT]   = st_reg.pin_s2[3:2];
      end
      OFS_CNT_SOURCE: begin
        rd_word[NCNT-1:0]             = st_reg.src_pulse;
        rd_word[SRC_MASK_LSB +: NCNT] = st_reg.ext_mask;
      end
      OFS_PULSE_PER:   rd_word[PER_W-1:0] = st_reg.pulse_per;
      default:         mapped = 1'b0;
    endcase

    // no wait state: answer built in setup, shown through the access cycle
    st_next.rsp.pready = setup;
    if (setup) begin
      st_next.rsp.prdata  = APB_REQ.pwrite ? RST_WORD : rd_word;
      st_next.rsp.pslverr = ~mapped;
    end else if (st_reg.rsp.pready) begin
      st_next.rsp.prdata  = RST_WORD;
      st_next.rsp.pslverr = 1'b0;
    end

    if (wr_access && mapped) begin
      unique case (APB_REQ.paddr)
        OFS_PULSE_ENV:   st_next.pulse_env   = APB_REQ.pwdata;
        OFS_PIN_ENV:     st_next.pin_env     = APB_REQ.pwdata;
        OFS_COUNTER_ENV: st_next.counter_env = APB_REQ.pwdata;
        OFS_OP_MODE:     st_next.op_mode     = APB_REQ.pwdata;
        OFS_EVT_ENABLE:  st_next.evt_enable  = APB_REQ.pwdata[EVT_LSB +: NCNT];
        OFS_EVT_CAUSE:   st_next.evt_cause   = st_reg.evt_cause
                                             & ~APB_REQ.pwdata[EVT_LSB +: NCNT];
        OFS_CMP_ONE:     st_next.cmp[0]      = APB_REQ.pwdata[CNT_W-1:0];
        OFS_CMP_TWO:     st_next.cmp[1]      = APB_REQ.pwdata[CNT_W-1:0];
        OFS_CNT_ONE:     st_next.cnt[0]      = APB_REQ.pwdata[CNT_W-1:0];
        OFS_CNT_TWO:     st_next.cnt[1]      = APB_REQ.pwdata[CNT_W-1:0];
        OFS_PIN_DATA:    st_next.gp_out      = APB_REQ.pwdata[NCNT-1:0];
        OFS_CNT_SOURCE: begin
          st_next.src_pulse = APB_REQ.pwdata[NCNT-1:0];
          st_next.ext_mask  = APB_REQ.pwdata[SRC_MASK_LSB +: NCNT];
        end
        OFS_PULSE_PER:   st_next.pulse_per   = APB_REQ.pwdata[PER_W-1:0];
        default:         st_next.pulse_per   = st_reg.pulse_per;
      endcase
    end

    // ----------------------------------------------------------------
    // event causes and interrupt
    // ----------------------------------------------------------------
    // a match onset in the clearing cycle survives: set beats clear
    st_next.evt_cause = st_next.evt_cause | (match_now & ~st_reg.match);
    st_next.int_n = ~|(st_next.evt_cause & st_next.evt_enable);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_reg           <= '0;
      st_reg.pulse_per <= RST_PER;
      st_reg.int_n     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PREADY                = st_reg.rsp.pready;
  assign PRDATA                = st_reg.rsp.prdata;
  assign PSLVERR               = st_reg.rsp.pslverr;
  assign MULTIPIN_DRV          = st_reg.pin_drv;
  assign PULSE_OUT             = st_reg.pulse_out;
  assign INT_N                 = st_reg.int_n;
  assign CMP_SHARE.cmp_value   = st_reg.cmp;
  assign CMP_SHARE.match_event = st_reg.match_evt;

endmodule : acsc_top
